// >>> src/sbl_map.svh
// Constants of the serial boot loader: offsets, field positions, reset values, timings.
// Assumes a 250 MHz core clock; included by bare name from the design files.
`ifndef SBL_MAP_SVH
`define SBL_MAP_SVH

`define SBL_CLK_PERIOD_PS 4000
`define SBL_INIT_TIME_US 1000
`define SBL_TXDRV_TIME_US 1300
// Least times, rounded up to whole cycles
`define SBL_INIT_CYCLES ((`SBL_INIT_TIME_US * 1000000 + `SBL_CLK_PERIOD_PS - 1) / `SBL_CLK_PERIOD_PS)
`define SBL_TXDRV_CYCLES ((`SBL_TXDRV_TIME_US * 1000000 + `SBL_CLK_PERIOD_PS - 1) / `SBL_CLK_PERIOD_PS)

`define SBL_MEAS_PRESCALE 2'h3
`define SBL_MEAS_OFFSET 16'h0024
`define SBL_MEAS_DIVISOR 16'h0048
`define SBL_BAUD_MULT 5

`define SBL_SYSTEM_CONFIG_WORD_BOOT 16'h0400
`define SBL_SYSTEM_CONFIG_WORD_BYTE_HIGH_DISABLE_BIT 9
`define SBL_BUSCON_ACTIVE_BIT 10
`define SBL_BUSCON_LATCH_BIT 9
`define SBL_BUSCON_TYPE_LSB 6
`define SBL_SERCON_BOOT 16'h8011
`define SBL_RAM_BASE 16'hFA40
`define SBL_LOAD_BYTES 6'h20
`define SBL_FLASH_LO 24'h01_0000
`define SBL_FLASH_HI 24'h08_FFFF

`define SBL_REG_STATUS 2'h0
`define SBL_REG_BAUD 2'h1
`define SBL_REG_CTRL 2'h2
`define SBL_CTRL_REARM_BIT 0

`endif

// >>> src/sbl_pkg.sv
// Types shared by the serial boot loader modules.
// Assumes sbl_map.svh holds the numeric constants.
package sbl_pkg;
    typedef enum logic [3:0] {
        ST_STRAP,
        ST_NORMAL,
        ST_INIT,
        ST_HUNT,
        ST_ARMED,
        ST_MEASURE,
        ST_DIVIDE,
        ST_TXWAIT,
        ST_ACK,
        ST_ACKWAIT,
        ST_LOAD,
        ST_RUN,
        ST_FAIL
    } sbl_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
    } sbl_wr_t;
endpackage

// >>> src/sbl_uart.sv
// Asynchronous serial channel: 8N1 receiver and transmitter, bit time 32*(reload+1) clocks.
// Assumes rx is synchronous to clk; the receiver holds a byte until it is taken or the next byte overwrites it.
`include "sbl_map.svh"
module sbl_uart (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic [12:0] reload,
    input wire logic rx,
    input wire logic rx_ready,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    input wire logic tx_start,
    input wire logic [7:0] tx_byte,
    output logic tx,
    output logic tx_busy
);
    logic [17:0] period;
    logic [17:0] rx_cnt_q;
    logic [3:0] rx_bit_q;
    logic rx_act_q;
    logic [7:0] rx_sh_q;
    logic [17:0] tx_cnt_q;
    logic [3:0] tx_bit_q;
    logic [9:0] tx_sh_q;

    assign period = {5'h00, reload} << `SBL_BAUD_MULT;

    // Receiver: half a bit to the start centre, then whole bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_act_q <= 1'b0;
            rx_cnt_q <= 18'h0_0000;
            rx_bit_q <= 4'h0;
            rx_sh_q <= 8'h00;
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
        end else begin
            if (rx_valid && rx_ready) begin
                rx_valid <= 1'b0;
            end
            if (!enable) begin
                rx_act_q <= 1'b0;
            end else if (!rx_act_q) begin
                if (!rx) begin
                    rx_act_q <= 1'b1;
                    rx_bit_q <= 4'h0;
                    rx_cnt_q <= (period + 18'h0_0020) >> 1;
                end
            end else if (rx_cnt_q > 18'h0_0001) begin
                rx_cnt_q <= rx_cnt_q - 18'h0_0001;
            end else begin
                rx_cnt_q <= period + 18'h0_0020;
                rx_bit_q <= rx_bit_q + 4'h1;
                if (rx_bit_q == 4'h0) begin
                    // Glitch, not a start bit
                    if (rx) begin
                        rx_act_q <= 1'b0;
                    end
                end else if (rx_bit_q < 4'h9) begin
                    rx_sh_q <= {rx, rx_sh_q[7:1]};
                end else begin
                    rx_act_q <= 1'b0;
                    // A byte not yet taken is overwritten
                    if (rx) begin
                        rx_valid <= 1'b1;
                        rx_byte <= rx_sh_q;
                    end
                end
            end
        end
    end

    // Transmitter: start, eight data bits LSB first, stop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_cnt_q <= 18'h0_0000;
            tx_bit_q <= 4'h0;
            tx_sh_q <= 10'h3FF;
            tx <= 1'b1;
            tx_busy <= 1'b0;
        end else if (!tx_busy) begin
            if (enable && tx_start) begin
                tx_sh_q <= {1'b1, tx_byte, 1'b0};
                tx_bit_q <= 4'h0;
                tx_cnt_q <= period + 18'h0_0020;
                tx <= 1'b0;
                tx_busy <= 1'b1;
            end
        end else if (tx_cnt_q > 18'h0_0001) begin
            tx_cnt_q <= tx_cnt_q - 18'h0_0001;
        end else if (tx_bit_q == 4'h9) begin
            tx_busy <= 1'b0;
            tx <= 1'b1;
        end else begin
            tx_cnt_q <= period + 18'h0_0020;
            tx_bit_q <= tx_bit_q + 4'h1;
            tx <= tx_sh_q[tx_bit_q + 4'h1];
        end
    end
endmodule

// >>> src/sbl_boot_loader.sv
// Serial boot loader: strap capture, zero-byte baud measurement, acknowledge, 32-byte load.
// Assumes all inputs synchronous to clk; RAM writes go through a two-entry buffer.
//
// Decided for this implementation: the address map and the plain strobed port.
`include "sbl_map.svh"
// Contract
// - Boot mode when select pin low at reset
// - Measure zero byte, set channel, drive transmit
// - Timer is 9/4 fcpu/baud; reload (T-36)/72
// - Baud equals fcpu over 32*(reload+1)
// - Return one fixed acknowledge byte
// - Transmit pin driven only after delay
// - Watchdog disabled in boot mode
// - Config word 0400h, byte disable from strap
// - Bus config from access pin and straps
// - Serial control 8011h, baud, pin latch, direction
// - Store 32 bytes from FA40 through FA5F
// - Then branch to FA40, stay in boot
// - Redirect code fetches from flash range
module sbl_boot_loader #(
    parameter int unsigned INIT_CYCLES = `SBL_INIT_CYCLES,
    parameter int unsigned TXDRV_CYCLES = `SBL_TXDRV_CYCLES,
    parameter logic [7:0] ACK_BYTE = 8'hA5 // Arbitrary value
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic boot_select_pin,
    input wire logic external_access_pin,
    input wire logic strap_bus_8bit,
    input wire logic [1:0] strap_bus_type,
    input wire logic boot_serial_rx,
    output logic boot_serial_tx_o,
    output logic boot_serial_tx_oe,
    output logic boot_loader_mode,
    output logic watchdog_disable,
    output logic [15:0] system_config_word,
    output logic [15:0] bus_config_zero,
    output logic [15:0] serial_control_reg,
    output logic [12:0] baud_generator_reg,
    output logic tx_pin_latch,
    output logic tx_pin_direction,
    output logic ram_wr_valid,
    output sbl_pkg::sbl_wr_t ram_wr,
    input wire logic ram_wr_ready,
    output logic cpu_jump,
    output logic [15:0] cpu_jump_addr,
    input wire logic [23:0] fetch_addr,
    input wire logic fetch_is_code,
    output logic fetch_redirect,
    input wire logic [1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata
);
    sbl_pkg::sbl_state_t state_q;
    logic [18:0] delay_q;
    logic [1:0] presc_q;
    logic [15:0] timer_q;
    logic [15:0] rem_q;
    logic [12:0] quot_q;
    logic fail_q;
    logic uart_en_q;
    logic [5:0] rx_count_q;
    logic rearm;
    logic uart_rx_valid;
    logic [7:0] uart_rx_byte;
    logic uart_tx;
    logic uart_tx_busy;
    logic ack_start_q;
    logic fifo_in_ready;
    logic push;
    logic pop;
    logic [1:0] count_q;
    sbl_pkg::sbl_wr_t entry1_q;
    sbl_pkg::sbl_wr_t push_entry;

    function automatic logic in_flash(input logic [23:0] a);
        in_flash = (a >= `SBL_FLASH_LO) && (a <= `SBL_FLASH_HI);
    endfunction

    assign rearm = reg_wr && (reg_addr == `SBL_REG_CTRL) && reg_wdata[`SBL_CTRL_REARM_BIT];
    assign fifo_in_ready = (count_q != 2'h2) && (state_q == sbl_pkg::ST_LOAD)
        && (rx_count_q != `SBL_LOAD_BYTES);
    assign push = uart_rx_valid && fifo_in_ready;
    assign pop = ram_wr_valid && ram_wr_ready;
    assign push_entry.addr = `SBL_RAM_BASE + {10'h000, rx_count_q};
    assign push_entry.data = uart_rx_byte;

    sbl_uart u_uart (
        .clk(clk),
        .rst_n(rst_n),
        .enable(uart_en_q),
        .reload(baud_generator_reg),
        .rx(boot_serial_rx),
        .rx_ready(fifo_in_ready),
        .rx_valid(uart_rx_valid),
        .rx_byte(uart_rx_byte),
        .tx_start(ack_start_q),
        .tx_byte(ACK_BYTE),
        .tx(uart_tx),
        .tx_busy(uart_tx_busy)
    );

    // Sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= sbl_pkg::ST_STRAP;
            delay_q <= 19'h0_0000;
            presc_q <= 2'h0;
            timer_q <= 16'h0000;
            rem_q <= 16'h0000;
            quot_q <= 13'h0000;
            ack_start_q <= 1'b0;
            rx_count_q <= 6'h00;
            cpu_jump <= 1'b0;
        end else begin
            ack_start_q <= 1'b0;
            cpu_jump <= 1'b0;
            if (push) begin
                rx_count_q <= rx_count_q + 6'h01;
            end
            if (rearm && boot_loader_mode) begin
                // Software restart of the measurement
                state_q <= sbl_pkg::ST_HUNT;
                rx_count_q <= 6'h00;
            end else begin
                case (state_q)
                    sbl_pkg::ST_STRAP: begin
                        // Strap is caught on the first edge after reset release
                        if (!boot_select_pin) begin
                            state_q <= sbl_pkg::ST_INIT;
                        end else begin
                            state_q <= sbl_pkg::ST_NORMAL;
                        end
                        delay_q <= 19'h0_0000;
                    end
                    sbl_pkg::ST_INIT: begin
                        // Host stays quiet meanwhile; a byte now is not measured
                        if (delay_q == 19'(INIT_CYCLES - 1)) begin
                            state_q <= sbl_pkg::ST_HUNT;
                        end else begin
                            delay_q <= delay_q + 19'h0_0001;
                        end
                    end
                    sbl_pkg::ST_HUNT: begin
                        if (boot_serial_rx) begin
                            state_q <= sbl_pkg::ST_ARMED;
                        end
                    end
                    sbl_pkg::ST_ARMED: begin
                        if (!boot_serial_rx) begin
                            state_q <= sbl_pkg::ST_MEASURE;
                            presc_q <= 2'h1;
                            timer_q <= 16'h0000;
                        end
                    end
                    sbl_pkg::ST_MEASURE: begin
                        // Timer runs at a quarter of the clock over nine low bits
                        presc_q <= presc_q + 2'h1;
                        if (boot_serial_rx) begin
                            state_q <= sbl_pkg::ST_DIVIDE;
                            rem_q <= (timer_q > `SBL_MEAS_OFFSET) ?
                                timer_q - `SBL_MEAS_OFFSET : 16'h0000;
                            quot_q <= 13'h0000;
                        end else if (presc_q == `SBL_MEAS_PRESCALE) begin
                            if (timer_q == 16'hFFFF) begin
                                // Baud too low for the 16-bit timer
                                state_q <= sbl_pkg::ST_FAIL;
                            end else begin
                                timer_q <= timer_q + 16'h0001;
                            end
                        end
                    end
                    sbl_pkg::ST_DIVIDE: begin
                        // Repeated subtraction; at most 909 steps
                        if (rem_q >= `SBL_MEAS_DIVISOR) begin
                            rem_q <= rem_q - `SBL_MEAS_DIVISOR;
                            quot_q <= quot_q + 13'h0001;
                        end else begin
                            state_q <= sbl_pkg::ST_TXWAIT;
                            delay_q <= 19'h0_0000;
                        end
                    end
                    sbl_pkg::ST_TXWAIT: begin
                        if (delay_q == 19'(TXDRV_CYCLES - 1)) begin
                            state_q <= sbl_pkg::ST_ACK;
                        end else begin
                            delay_q <= delay_q + 19'h0_0001;
                        end
                    end
                    sbl_pkg::ST_ACK: begin
                        ack_start_q <= 1'b1;
                        state_q <= sbl_pkg::ST_ACKWAIT;
                    end
                    sbl_pkg::ST_ACKWAIT: begin
                        if (!ack_start_q && !uart_tx_busy) begin
                            state_q <= sbl_pkg::ST_LOAD;
                            rx_count_q <= 6'h00;
                        end
                    end
                    sbl_pkg::ST_LOAD: begin
                        // Jump only when the last byte has left the buffer
                        if (rx_count_q == `SBL_LOAD_BYTES && count_q == 2'h0) begin
                            state_q <= sbl_pkg::ST_RUN;
                            cpu_jump <= 1'b1;
                        end
                    end
                    sbl_pkg::ST_RUN, sbl_pkg::ST_NORMAL, sbl_pkg::ST_FAIL: begin
                        state_q <= state_q;
                    end
                    default: begin
                        state_q <= sbl_pkg::ST_STRAP;
                    end
                endcase
            end
        end
    end

    // Mode and configuration words, set from the straps at entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_loader_mode <= 1'b0;
            watchdog_disable <= 1'b0;
            system_config_word <= 16'h0000;
            bus_config_zero <= 16'h0000;
        end else if (state_q == sbl_pkg::ST_STRAP && !boot_select_pin) begin
            boot_loader_mode <= 1'b1;
            watchdog_disable <= 1'b1;
            system_config_word <= `SBL_SYSTEM_CONFIG_WORD_BOOT
                | ({15'h0000, strap_bus_8bit} << `SBL_SYSTEM_CONFIG_WORD_BYTE_HIGH_DISABLE_BIT);
            if (external_access_pin) begin
                bus_config_zero <= 16'h0000;
            end else begin
                bus_config_zero <= (16'h0001 << `SBL_BUSCON_ACTIVE_BIT)
                    | (16'h0001 << `SBL_BUSCON_LATCH_BIT)
                    | ({14'h0000, strap_bus_type} << `SBL_BUSCON_TYPE_LSB);
            end
        end
    end

    // Serial channel setup after measurement
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            uart_en_q <= 1'b0;
            serial_control_reg <= 16'h0000;
            baud_generator_reg <= 13'h0000;
            tx_pin_latch <= 1'b0;
            tx_pin_direction <= 1'b0;
        end else if (state_q == sbl_pkg::ST_DIVIDE && rem_q < `SBL_MEAS_DIVISOR) begin
            uart_en_q <= 1'b1;
            serial_control_reg <= `SBL_SERCON_BOOT;
            baud_generator_reg <= quot_q;
            tx_pin_latch <= 1'b1;
            tx_pin_direction <= 1'b1;
        end
    end

    // Pin stays released until the drive delay has run out
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_serial_tx_o <= 1'b1;
            boot_serial_tx_oe <= 1'b0;
        end else begin
            boot_serial_tx_o <= uart_tx;
            if (state_q == sbl_pkg::ST_TXWAIT && delay_q == 19'(TXDRV_CYCLES - 1)) begin
                boot_serial_tx_oe <= 1'b1;
            end
        end
    end

    // Two-entry buffer; head entry drives the RAM port directly
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 2'h0;
            ram_wr_valid <= 1'b0;
            ram_wr <= '0;
            entry1_q <= '0;
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (count_q == 2'h0) begin
                        ram_wr <= push_entry;
                    end else begin
                        entry1_q <= push_entry;
                    end
                    count_q <= count_q + 2'h1;
                    ram_wr_valid <= 1'b1;
                end
                2'b01: begin
                    ram_wr <= entry1_q;
                    count_q <= count_q - 2'h1;
                    ram_wr_valid <= (count_q == 2'h2);
                end
                2'b11: begin
                    if (count_q == 2'h1) begin
                        ram_wr <= push_entry;
                    end else begin
                        ram_wr <= entry1_q;
                        entry1_q <= push_entry;
                    end
                end
                default: begin
                    count_q <= count_q;
                end
            endcase
        end
    end

    // Overflow flag: set wins over a same-cycle clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fail_q <= 1'b0;
        end else if (state_q == sbl_pkg::ST_MEASURE && !boot_serial_rx
            && presc_q == `SBL_MEAS_PRESCALE && timer_q == 16'hFFFF) begin
            fail_q <= 1'b1;
        end else if (rearm) begin
            fail_q <= 1'b0;
        end
    end

    // Jump target and code fetch redirection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_jump_addr <= 16'h0000;
            fetch_redirect <= 1'b0;
        end else begin
            cpu_jump_addr <= `SBL_RAM_BASE;
            // Data reads are never redirected
            fetch_redirect <= boot_loader_mode && fetch_is_code && in_flash(fetch_addr);
        end
    end

    // Register read port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `SBL_REG_STATUS: begin
                    reg_rdata <= {boot_loader_mode, fail_q, uart_en_q, boot_serial_tx_oe,
                        2'b00, rx_count_q, state_q};
                end
                `SBL_REG_BAUD: begin
                    reg_rdata <= {3'b000, baud_generator_reg};
                end
                `SBL_REG_CTRL: begin
                    reg_rdata <= 16'h0000;
                end
                default: begin
                    reg_rdata <= 16'h0000;
                end
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule

// >>> tb/sbl_sva.sv
// Port checker for the serial boot loader.
// Assumes one clock domain; bound to every loader instance.
module sbl_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic external_access_pin,
    input wire logic strap_bus_8bit,
    input wire logic [1:0] strap_bus_type,
    input wire logic boot_serial_tx_oe,
    input wire logic boot_loader_mode,
    input wire logic watchdog_disable,
    input wire logic [15:0] system_config_word,
    input wire logic [15:0] bus_config_zero,
    input wire logic [15:0] serial_control_reg,
    input wire logic tx_pin_latch,
    input wire logic tx_pin_direction,
    input wire logic ram_wr_valid,
    input wire sbl_pkg::sbl_wr_t ram_wr,
    input wire logic ram_wr_ready,
    input wire logic cpu_jump,
    input wire logic [15:0] cpu_jump_addr,
    input wire logic [23:0] fetch_addr,
    input wire logic fetch_is_code,
    input wire logic fetch_redirect
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_wdog; boot_loader_mode == watchdog_disable; endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog state wrong");
    property p_sys; boot_loader_mode |-> system_config_word ==
        (16'h0400 | {6'h00, strap_bus_8bit, 9'h000}); endproperty
    a_sys: assert property (p_sys) else $error("config word wrong");
    property p_bus; boot_loader_mode |-> bus_config_zero == (external_access_pin ? 16'h0000 :
        (16'h0600 | {8'h00, strap_bus_type, 6'h00})); endproperty
    a_bus: assert property (p_bus) else $error("bus config wrong");
    property p_scon; serial_control_reg[15] |-> serial_control_reg == 16'h8011
        && tx_pin_latch && tx_pin_direction; endproperty
    a_scon: assert property (p_scon) else $error("serial setup wrong");
    // Line stays undriven for a while after setup
    property p_late; $rose(serial_control_reg[15]) |-> !boot_serial_tx_oe [*8]; endproperty
    a_late: assert property (p_late) else $error("tx driven too early");
    property p_addr; ram_wr_valid |-> ram_wr.addr >= 16'hFA40 && ram_wr.addr <= 16'hFA5F;
    endproperty
    a_addr: assert property (p_addr) else $error("ram address out of range");
    property p_hold; ram_wr_valid && !ram_wr_ready |=> ram_wr_valid && $stable(ram_wr);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled write lost");
    property p_jump; cpu_jump |-> cpu_jump_addr == 16'hFA40 && !ram_wr_valid
        && boot_loader_mode ##1 !cpu_jump; endproperty
    a_jump: assert property (p_jump) else $error("jump wrong");
    property p_redir; boot_loader_mode && fetch_is_code && fetch_addr >= 24'h01_0000
        && fetch_addr <= 24'h08_FFFF |=> fetch_redirect; endproperty
    a_redir: assert property (p_redir) else $error("code fetch not redirected");
endmodule
bind sbl_boot_loader sbl_sva i_sbl_sva (.clk, .rst_n, .external_access_pin, .strap_bus_8bit,
    .strap_bus_type, .boot_serial_tx_oe, .boot_loader_mode, .watchdog_disable,
    .system_config_word, .bus_config_zero, .serial_control_reg, .tx_pin_latch,
    .tx_pin_direction, .ram_wr_valid, .ram_wr, .ram_wr_ready, .cpu_jump, .cpu_jump_addr,
    .fetch_addr, .fetch_is_code, .fetch_redirect);

// >>> tb/sbl_host.sv
// Host programmer model on the serial boot line.
// Assumes the caller starts each task just after a rising edge.
module sbl_host (
    input wire logic clk,
    input wire logic line_in,
    output logic line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Exact match to reload 3, far from overflow
    localparam int BIT_CLKS = 128;
    initial line_out = 1'b1;
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 10; i++) begin
            line_out <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
            repeat (BIT_CLKS) @(posedge clk);
        end
    endtask
    task automatic get_byte(output logic [7:0] b, output logic ok);
        for (int n = 0; n < 5000 && line_in !== 1'b0; n++) @(posedge clk);
        repeat (BIT_CLKS / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            b[i] = line_in;
        end
        repeat (BIT_CLKS) @(posedge clk);
        ok = line_in;
        // Let the device leave its acknowledge phase first
        repeat (2 * BIT_CLKS) @(posedge clk);
    endtask
endmodule

// >>> tb/tb.sv
// Testbench: straps, fetch redirect, serial boot load and register reads.
// Assumes a pulled-up transmit line and the host model on the serial pins.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ACK = 8'h3C; // Arbitrary value
    logic clk = 1'b0, rst_n = 1'b0, sel = 1'b1, ea = 1'b1, b8 = 1'b1, ready = 1'b1;
    logic code = 1'b0, rd = 1'b0, wr = 1'b0, rx, tx_o, tx_oe, mode, wdog, jump, redir;
    logic ok, latch, dir, wv;
    logic [1:0] ra = 2'h0;
    logic [15:0] wd = 16'h0000, sysw, busw, scon, jaddr, rdata;
    logic [23:0] fa = 24'h00_0000;
    logic [12:0] baud;
    logic [7:0] ack;
    sbl_pkg::sbl_wr_t wrd;
    int miscompares = 0, check_count = 0, nwr = 0, njump = 0, cyc = 0;
    wire line = tx_oe ? tx_o : 1'b1; // Pull-up while undriven
    initial forever #2 clk = ~clk;
    sbl_boot_loader #(.INIT_CYCLES(20), .TXDRV_CYCLES(400), .ACK_BYTE(ACK)) i_sbl_boot_loader (
        .clk(clk), .rst_n(rst_n), .boot_select_pin(sel), .external_access_pin(ea),
        .strap_bus_8bit(b8), .strap_bus_type(2'h2), .boot_serial_rx(rx),
        .boot_serial_tx_o(tx_o), .boot_serial_tx_oe(tx_oe), .boot_loader_mode(mode),
        .watchdog_disable(wdog), .system_config_word(sysw), .bus_config_zero(busw),
        .serial_control_reg(scon), .baud_generator_reg(baud), .tx_pin_latch(latch),
        .tx_pin_direction(dir), .ram_wr_valid(wv), .ram_wr(wrd), .ram_wr_ready(ready),
        .cpu_jump(jump), .cpu_jump_addr(jaddr), .fetch_addr(fa), .fetch_is_code(code),
        .fetch_redirect(redir), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdata));
    sbl_host i_sbl_host (.clk(clk), .line_in(line), .line_out(rx));
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cfg(input logic s, input logic e, input logic b);
        @(posedge clk);
        rst_n <= 1'b0;
        sel <= s;
        ea <= e;
        b8 <= b;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("mode", 24'(!s), 24'(mode));
        chk("wdog", 24'(!s), 24'(wdog));
        chk("system_config_word", s ? 24'h00_0000 : (b ? 24'h00_0600 : 24'h00_0400), 24'(sysw));
        chk("buscon", (s || e) ? 24'h00_0000 : 24'h00_0680, 24'(busw));
        $display("test config done");
    endtask
    task automatic rw(input logic w, input logic [1:0] a, input logic [15:0] e, input string nm);
        @(posedge clk);
        ra <= a;
        wd <= e;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        if (!w) chk(nm, 24'(e), 24'(rdata));
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            miscompares++;
            final_report();
        end
        if (rst_n && wv && ready) begin
            chk("ram_addr", 24'(16'hFA40 + 16'(nwr)), 24'(wrd.addr));
            chk("ram_data", 24'(8'h5A ^ 8'(nwr)), 24'(wrd.data));
            nwr++;
        end
        if (jump === 1'b1) begin
            chk("jump_addr", 24'h00_FA40, 24'(jaddr));
            chk("jump_after", 24'h00_0020, 24'(nwr));
            njump++;
        end
    end
    initial begin
        cfg(1'b1, 1'b1, 1'b1);
        cfg(1'b0, 1'b1, 1'b1);
        cfg(1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            code <= (i != 4);
            fa <= (i == 0) ? 24'h01_0000 : (i == 1) ? 24'h08_FFFF : (i == 2) ? 24'h00_FFFF :
                  (i == 3) ? 24'h09_0000 : 24'h04_0000;
            @(posedge clk);
            #1;
            chk("redirect", 24'(i < 2), 24'(redir));
        end
        $display("test fetch done");
        repeat (40) @(posedge clk);
        i_sbl_host.send_byte(8'h00);
        chk("oe_early", 24'h00_0000, 24'(tx_oe));
        i_sbl_host.get_byte(ack, ok);
        chk("ack", 24'(ACK), 24'(ack));
        chk("ack_stop", 24'h00_0001, 24'(ok));
        chk("oe", 24'h00_0001, 24'(tx_oe));
        chk("baud", 24'h00_0003, 24'(baud));
        chk("sercon", 24'h00_8011, 24'(scon));
        chk("pin", 24'h00_0003, 24'({latch, dir}));
        @(posedge clk);
        ready <= 1'b0;
        // Stall long enough to fill both buffer entries, not long enough to lose a byte
        fork
            for (int n = 0; n < 32; n++) i_sbl_host.send_byte(8'h5A ^ 8'(n));
            begin
                repeat (3400) @(posedge clk);
                ready <= 1'b1;
            end
        join
        for (int k = 0; k < 1000 && njump == 0; k++) @(posedge clk);
        chk("jumps", 24'h00_0001, 24'(njump));
        $display("test boot done");
        rw(1'b0, 2'h1, 16'h0003, "baud_reg");
        rw(1'b0, 2'h3, 16'h0000, "unmapped");
        rw(1'b1, 2'h0, 16'hFFFF, "");
        rw(1'b0, 2'h0, {4'hB, 2'h0, 6'h20, 4'(sbl_pkg::ST_RUN)}, "status");
        rw(1'b1, 2'h2, 16'h0001, "");
        rw(1'b0, 2'h0, {4'hB, 2'h0, 6'h00, 4'(sbl_pkg::ST_ARMED)}, "rearm");
        $display("test registers done");
        final_report();
    end
endmodule
